// ==== hdl/sbi_transmitter.sv ====
// Serial transmitter with break and idle-line generation and its registers
`timescale 1ns/1ps

module sbi_transmitter #(
    parameter int BAUD_W = sbi_pkg::BAUD_W
) (
    input  wire logic                      clk_in,
    input  wire logic                      reset_n_in,
    input  wire logic [sbi_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [sbi_pkg::DATA_W-1:0] wdata_in,
    input  wire logic                      wr_in,
    input  wire logic                      rd_in,
    output logic      [sbi_pkg::DATA_W-1:0] rdata_out,
    output logic                           tx_out
);

    // ****************************************
    // State
    // ****************************************
    sbi_pkg::sbi_ctrl_t ctrl;
    sbi_pkg::sbi_kind_t kind;
    logic [BAUD_W-1:0]  baud;
    logic [8:0]         data_buf;
    logic               data_pend;
    logic               idle_pend;
    logic               brk_pend;
    logic [11:0]        shreg;
    logic [3:0]         left;
    logic               tick;

    // ****************************************
    // Register decode
    // ****************************************
    sbi_pkg::sbi_ctrl_t wr_ctrl_val;
    wire                wr_ctrl = wr_in && (addr_in == sbi_pkg::OFS_CTRL);
    wire                wr_data = wr_in && (addr_in == sbi_pkg::OFS_DATA);
    wire                wr_baud = wr_in && (addr_in == sbi_pkg::OFS_BAUD);
    assign wr_ctrl_val = sbi_pkg::sbi_ctrl_t'(wdata_in[3:0]);

    // Rising edges of send-break and transmit-enable raise requests
    wire set_brk  = wr_ctrl && wr_ctrl_val.send_break_bit && !ctrl.send_break_bit;
    wire set_idle = wr_ctrl && wr_ctrl_val.transmit_enable && !ctrl.transmit_enable;

    // ****************************************
    // Frame scheduling
    // ****************************************
    wire busy       = (left != sbi_pkg::LEN_ZERO);
    wire can_start  = ctrl.transmit_enable && !busy;
    // Idle first, then break, then data; a held send-break repeats breaks
    wire start_idle = can_start && idle_pend;
    wire start_brk  = can_start && !idle_pend && (brk_pend || ctrl.send_break_bit);
    wire start_data = can_start && !idle_pend && !brk_pend && !ctrl.send_break_bit && data_pend;
    wire start_any  = start_idle || start_brk || start_data;

    // Frame length follows the word-length select
    wire [3:0] flen = ctrl.word_len ? sbi_pkg::LEN_LONG : sbi_pkg::LEN_SHORT;

    // Break: flen low bits then one high bit, so the line recovers
    wire [11:0] brk_pat  = 12'h001 << flen;
    wire [11:0] data_pat = ctrl.word_len ? {1'b0, 1'b1, data_buf, 1'b0}
                                         : {2'b00, 1'b1, data_buf[7:0], 1'b0};
    wire [11:0] load_pat = start_idle ? 12'hfff : (start_brk ? brk_pat : data_pat);
    wire [3:0]  load_len = start_brk ? 4'(flen + sbi_pkg::LEN_ONE) : flen;

    // Pending flags: a new request wins over the consuming start
    wire next_brk_pend  = set_brk || (brk_pend && !start_brk);
    wire next_idle_pend = set_idle || (idle_pend && !start_idle);
    wire next_data_pend = wr_data || (data_pend && !start_data);

    // ****************************************
    // Bit timing
    // ****************************************
    sbi_baud_tick #(.W(BAUD_W)) u_tick (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .restart_in (start_any),
        .divider_in (baud),
        .tick_out   (tick)
    );

    // ****************************************
    // Registers written by software
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            ctrl     <= sbi_pkg::sbi_ctrl_t'(sbi_pkg::CTRL_RESET);
            baud     <= BAUD_W'(sbi_pkg::BAUD_RESET);
            data_buf <= sbi_pkg::DATA_RESET;
        end else begin
            if (wr_ctrl) ctrl <= wr_ctrl_val;
            if (wr_baud) baud <= wdata_in[BAUD_W-1:0];
            if (wr_data) data_buf <= wdata_in[8:0];
        end
    end

    // Request flags
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            brk_pend  <= 1'b0;
            idle_pend <= 1'b0;
            data_pend <= 1'b0;
        end else begin
            brk_pend  <= next_brk_pend;
            idle_pend <= next_idle_pend;
            data_pend <= next_data_pend;
        end
    end

    // ****************************************
    // Shifter and line driver
    // ****************************************
    // Length is fixed at load, so a request mid-frame cannot stretch a break
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            shreg  <= 12'hfff;
            left   <= sbi_pkg::LEN_ZERO;
            kind   <= sbi_pkg::SBI_KIND_NONE;
            tx_out <= 1'b1;
        end else if (start_any) begin
            shreg  <= load_pat;
            left   <= load_len;
            kind   <= start_idle ? sbi_pkg::SBI_KIND_IDLE :
                      (start_brk ? sbi_pkg::SBI_KIND_BREAK : sbi_pkg::SBI_KIND_DATA);
            tx_out <= load_pat[0];
        end else if (busy && tick) begin
            shreg  <= {1'b1, shreg[11:1]};
            left   <= 4'(left - sbi_pkg::LEN_ONE);
            tx_out <= (left == sbi_pkg::LEN_ONE) ? 1'b1 : shreg[1];
        end
    end

    // ****************************************
    // Read port
    // ****************************************
    // Unmapped addresses read as zero; data stand one cycle only
    wire [sbi_pkg::DATA_W-1:0] stat_val = {10'h000, kind, brk_pend, idle_pend, data_pend, busy};
    wire [sbi_pkg::DATA_W-1:0] rd_mux =
        (addr_in == sbi_pkg::OFS_CTRL) ? {12'h000, ctrl} :
        (addr_in == sbi_pkg::OFS_DATA) ? {7'h00, data_buf} :
        (addr_in == sbi_pkg::OFS_BAUD) ? {4'h0, baud} :
        (addr_in == sbi_pkg::OFS_STAT) ? stat_val : 16'h0000;

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) rdata_out <= 16'h0000;
        else             rdata_out <= rd_in ? rd_mux : 16'h0000;
    end

    // ****************************************
    // Checks
    // ****************************************
    AST_ONE_BREAK: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        start_brk |-> (brk_pend || ctrl.send_break_bit))
        else $error("break started without a request");

    AST_LEN_SHORT: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (start_brk && !ctrl.word_len) |=> (left == 4'hb) && !tx_out)
        else $error("short break frame has wrong length");

    AST_LEN_LONG: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (start_brk && ctrl.word_len) |=> (left == 4'hc) && !tx_out)
        else $error("long break frame has wrong length");

    AST_REPEAT: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        ($fell(busy) && ctrl.send_break_bit && ctrl.transmit_enable && !idle_pend)
        |-> start_brk)
        else $error("held send-break did not repeat the break");

    AST_IDLE_FIRST: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (start_brk || start_data) |-> !idle_pend)
        else $error("frame overtook a queued idle frame");

    AST_IDLE_THEN_BRK: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        ($fell(busy) && kind == sbi_pkg::SBI_KIND_IDLE && brk_pend && ctrl.transmit_enable
         && !idle_pend) |-> start_brk ##1 (left == 4'(flen + 4'h1)))
        else $error("break after idle not started with its length");

    AST_BRK_STOP: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (kind == sbi_pkg::SBI_KIND_BREAK && left == 4'h1 && !start_any) |-> tx_out)
        else $error("break frame did not end high");

endmodule : sbi_transmitter

// ==== pkg/sbi_pkg.sv ====
// Constants, register map and types of the break and idle-line transmitter
package sbi_pkg;

    // ****************************************
    // Bus and register map
    // ****************************************
    localparam int          ADDR_W     = 4;
    localparam int          DATA_W     = 16;
    localparam int          BAUD_W     = 12;
    localparam logic [3:0]  OFS_CTRL   = 4'h0;
    localparam logic [3:0]  OFS_DATA   = 4'h4;
    localparam logic [3:0]  OFS_BAUD   = 4'h8;
    localparam logic [3:0]  OFS_STAT   = 4'hc;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [3:0]  CTRL_RESET = 4'h0;
    localparam logic [11:0] BAUD_RESET = 12'h010;
    localparam logic [8:0]  DATA_RESET = 9'h000;

    // ****************************************
    // Frame lengths in bit times
    // ****************************************
    localparam logic [3:0]  LEN_SHORT  = 4'ha;  // Word-length select at zero
    localparam logic [3:0]  LEN_LONG   = 4'hb;  // Word-length select at one
    localparam logic [3:0]  LEN_ZERO   = 4'h0;
    localparam logic [3:0]  LEN_ONE    = 4'h1;

    // Control register fields, bit 3 downward
    typedef struct packed {
        logic ninth_bit;
        logic word_len;
        logic transmit_enable;
        logic send_break_bit;
    } sbi_ctrl_t;

    // Kind of frame on the line
    typedef enum logic [1:0] {
        SBI_KIND_NONE  = 2'b00,
        SBI_KIND_IDLE  = 2'b01,
        SBI_KIND_BREAK = 2'b10,
        SBI_KIND_DATA  = 2'b11
    } sbi_kind_t;

endpackage : sbi_pkg

// ==== hdl/sbi_baud_tick.sv ====
// Bit-time tick generator, restartable at the start of each frame
`timescale 1ns/1ps

module sbi_baud_tick #(
    parameter int W = 12
) (
    input  wire logic         clk_in,
    input  wire logic         reset_n_in,
    input  wire logic         restart_in,
    input  wire logic [W-1:0] divider_in,
    output logic              tick_out
);

    logic [W-1:0] cnt;

    // Tick ends a bit; a divider of zero behaves as one
    assign tick_out = (cnt >= divider_in);

    // Restart aligns the first bit exactly with the frame load
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            cnt <= {{(W-1){1'b0}}, 1'b1};
        end else if (restart_in || tick_out) begin
            cnt <= {{(W-1){1'b0}}, 1'b1};
        end else begin
            cnt <= W'(cnt + 1'b1);
        end
    end

endmodule : sbi_baud_tick

// ==== bench/sbi_line_monitor.sv ====
// Remote receiver model that times low and high runs on the line
`timescale 1ns/1ps

module sbi_line_monitor (
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    input  wire logic line_in,
    output int        low_runs_out,
    output int        last_low_out,
    output int        min_gap_out
);
    logic prev;
    int   run;

    // ****************************************
    // Run timing
    // ****************************************
    // Listens only; the line is never driven from here
    always @(posedge clk_in) begin
        if (!reset_n_in) begin
            prev         <= 1'b1;
            run          <= 0;
            low_runs_out <= 0;
            last_low_out <= 0;
            min_gap_out  <= 1000000;
        end else begin
            prev <= line_in;
            run  <= (line_in != prev) ? 1 : run + 1;
            if (prev && !line_in) begin
                low_runs_out <= low_runs_out + 1;
                // Gap before the first low is the reset idle, not a frame gap
                if (low_runs_out > 0 && run < min_gap_out)
                    min_gap_out <= run;
            end
            if (!prev && line_in)
                last_low_out <= run;
        end
    end
endmodule : sbi_line_monitor

// ==== bench/sbi_transmitter_bench.sv ====
// Self-checking bench of the break and idle-line transmitter
`timescale 1ns/1ps

module sbi_transmitter_bench;
    localparam int LIMIT = 20000;  // Far above the fewer than two thousand cycles needed
    logic        clk_in     = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [3:0]  addr       = 4'h0;
    logic [15:0] wdata      = 16'h0000;
    logic        wr         = 1'b0;
    logic        rd         = 1'b0;
    logic [15:0] rdata;
    logic        tx;
    logic [15:0] d;
    int          fails = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          baud, n, t, cnt, low_runs, last_low, min_gap;

    sbi_transmitter i_sbi_transmitter (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .tx_out(tx));
    sbi_line_monitor i_sbi_line_monitor (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .line_in(tx), .low_runs_out(low_runs), .last_low_out(last_low),
        .min_gap_out(min_gap));

    // ****************************************
    // Clock, timeout and helpers
    // ****************************************
    always #2.5 clk_in = ~clk_in;

    // A hang counts as a mismatch and closes the run
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            fails = fails + 1;
            wrap_up();
        end
    end

    task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    task automatic wr_reg(logic [3:0] a, logic [15:0] v);
        @(posedge clk_in);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk_in);
        wr    <= 1'b0;
    endtask : wr_reg

    // Data stand only in the cycle after the strobe
    task automatic rd_reg(logic [3:0] a);
        @(posedge clk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_in);
        rd   <= 1'b0;
        @(negedge clk_in);
        d = rdata;
    endtask : rd_reg

    // Long high stretch means every queued frame has left
    task automatic quiet();
        cnt = 0;
        while (cnt < 30 * baud) begin
            @(posedge clk_in);
            cnt = (tx === 1'b1) ? cnt + 1 : 0;
        end
    endtask : quiet

    function automatic int brk_len(int wl, int b);
        return (wl != 0 ? int'(sbi_pkg::LEN_LONG) : int'(sbi_pkg::LEN_SHORT)) * b;
    endfunction : brk_len

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    initial begin
        void'($urandom(32'h0574));
        baud = 2 + $urandom % 3;
        repeat (3) @(posedge clk_in);
        reset_n_in <= 1'b1;
        rd_reg(sbi_pkg::OFS_CTRL);
        chk("ctrl_reset", 32'h0, d);
        rd_reg(sbi_pkg::OFS_BAUD);
        chk("baud_reset", 32'h10, d);
        wr_reg(4'h2, 16'hffff);
        rd_reg(4'h2);
        chk("unmapped", 32'h0, d);
        wr_reg(sbi_pkg::OFS_BAUD, 16'(baud));
        rd_reg(sbi_pkg::OFS_BAUD);
        chk("baud", baud, d);
        // One break per word length, idle requested first
        for (int wl = 0; wl < 2; wl++) begin
            n = low_runs;
            wr_reg(sbi_pkg::OFS_CTRL, 16'(wl * 4));
            wr_reg(sbi_pkg::OFS_CTRL, 16'(wl * 4 + 2));
            wr_reg(sbi_pkg::OFS_CTRL, 16'(wl * 4 + 3));
            wr_reg(sbi_pkg::OFS_CTRL, 16'(wl * 4 + 2));
            rd_reg(sbi_pkg::OFS_STAT);
            chk("stat_idle", 32'h3, {d[5:4], d[0]});
            quiet();
            chk("break_count", n + 1, low_runs);
            chk("break_len", brk_len(wl, baud), last_low);
        end
        // Held send-break, released at a random moment
        n = low_runs;
        wr_reg(sbi_pkg::OFS_CTRL, 16'h0);
        wr_reg(sbi_pkg::OFS_CTRL, 16'h2);
        wr_reg(sbi_pkg::OFS_CTRL, 16'h3);
        repeat (40 * baud + $urandom % (20 * baud)) @(posedge clk_in);
        wr_reg(sbi_pkg::OFS_CTRL, 16'h2);
        repeat (3) @(posedge clk_in);
        t = low_runs;
        quiet();
        chk("repeats", 32'h1, (low_runs - n) >= 2);
        chk("no_extra", t, low_runs);
        chk("repeat_len", brk_len(0, baud), last_low);
        // Character queued right behind an idle request
        wr_reg(sbi_pkg::OFS_CTRL, 16'h0);
        wr_reg(sbi_pkg::OFS_CTRL, 16'h2);
        t = cyc;
        wr_reg(sbi_pkg::OFS_DATA, 16'h00fe);
        cnt = 0;
        while (tx === 1'b1 && cnt < 1000) begin
            @(posedge clk_in);
            cnt++;
        end
        chk("idle_first", 32'h1, (cyc - t) >= 10 * baud);
        quiet();
        chk("data_start", 2 * baud, last_low);
        chk("min_gap", 32'h1, min_gap >= baud);
        // Nine-bit character: start and eight zero bits low, ninth bit high
        wr_reg(sbi_pkg::OFS_CTRL, 16'h6);
        wr_reg(sbi_pkg::OFS_DATA, 16'h0100);
        rd_reg(sbi_pkg::OFS_DATA);
        chk("data_reg", 32'h100, d);
        quiet();
        chk("nine_bit_low", 9 * baud, last_low);
        rd_reg(sbi_pkg::OFS_STAT);
        chk("stat_done", 32'h0, d[0]);
        wrap_up();
    end
endmodule : sbi_transmitter_bench
